// ===== core/twd_pkg.sv
// constants shared by the touch wheel detect, position and calibration block
// Functional notes
// - touch flag pin and response bit 7
// - touch flag floats about 400 us after wake
// - detect only one or two unbalanced channels
// - 7-bit position only while touched
// - point three 0/127, one 43, two 85
// - calibrate at power-up or command 0x01
// - commanded calibration: 10 bursts 1 ms apart
// - power-up calibration adds 6 bursts
// - no communication, ready low during calibration
// - error flag is response bit 1
// - error from finger calibrated away, then removed
// - drift compensation only on drift command
// - 500 us settle after wake, none otherwise
// - standard response always, one transfer late
// - 8 bits MSB first, shift fall, sample rise
// - select fall then rise starts one burst
package twd_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int BURST_GAP_US = 1000;
  localparam int WAKE_FLOAT_US = 400;
  localparam int WAKE_SETTLE_US = 500;
  localparam int BURST_GAP_CYC = BURST_GAP_US * CLK_MHZ;
  localparam int WAKE_FLOAT_CYC = WAKE_FLOAT_US * CLK_MHZ;
  localparam int WAKE_SETTLE_CYC = WAKE_SETTLE_US * CLK_MHZ;
  localparam int TMR_W = 20;
  // ----------------------------------------------------------------
  // calibration
  // ----------------------------------------------------------------
  localparam int CAL_W = 5;
  localparam logic [CAL_W-1:0] CAL_BURSTS = 5'h0a;
  localparam logic [CAL_W-1:0] PWRUP_EXTRA_BURSTS = 5'h06;
  // ----------------------------------------------------------------
  // serial frame and commands
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_BITS = 4'h8;
  localparam logic [7:0] CMD_CAL = 8'h01;
  localparam logic [7:0] CMD_DRIFT = 8'h03;
  localparam logic [7:0] CMD_ERROR = 8'h04;
  localparam int RSP_TOUCH_BIT = 7;
  localparam int RSP_ERROR_BIT = 1;
  // ----------------------------------------------------------------
  // position encoding
  // ----------------------------------------------------------------
  localparam logic [6:0] POS_PT3_LO = 7'h00;
  localparam logic [6:0] POS_PT1 = 7'h2b;
  localparam logic [6:0] POS_PT2 = 7'h55;
  localparam logic [6:0] POS_PT3_HI = 7'h7f;
endpackage

// ===== core/twd_pos_calc.sv
// position interpolation between the two strongest sense points
`timescale 1ns/1ps
module twd_pos_calc #(
  parameter int CW = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // channel magnitudes and control
  input wire logic [CW-1:0] mag_one,
  input wire logic [CW-1:0] mag_two,
  input wire logic [CW-1:0] mag_three,
  input wire logic load,
  input wire logic valid,
  input wire logic clr,
  // result
  output logic [6:0] pos
);
  typedef struct packed {
    logic [6:0] pos;
  } twd_calc_s;

  twd_calc_s s_r, s_nxt;
  logic [CW-1:0] ma, mb;
  logic [6:0] base, span;
  logic [CW:0] den;
  logic [CW+6:0] num, quo;

  always_comb begin
    // the weakest channel is the far point; interpolate between the other two
    if (mag_three <= mag_one && mag_three <= mag_two) begin
      ma = mag_one;
      mb = mag_two;
      base = twd_pkg::POS_PT1;
      span = twd_pkg::POS_PT2 - twd_pkg::POS_PT1;
    end else if (mag_one <= mag_two) begin
      ma = mag_two;
      mb = mag_three;
      base = twd_pkg::POS_PT2;
      span = twd_pkg::POS_PT3_HI - twd_pkg::POS_PT2;
    end else begin
      ma = mag_three;
      mb = mag_one;
      base = twd_pkg::POS_PT3_LO;
      span = twd_pkg::POS_PT1 - twd_pkg::POS_PT3_LO;
    end
    den = {1'b0, ma} + {1'b0, mb};
    num = {7'h00, mb} * {{CW{1'b0}}, span};
    quo = (den == '0) ? '0 : num / {6'h00, den};
    s_nxt = s_r;
    if (clr) begin
      s_nxt.pos = 7'h00;
    end else if (load) begin
      s_nxt.pos = valid ? base + quo[6:0] : 7'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pos = s_r.pos;
endmodule // twd_pos_calc

// ===== core/twd_core.sv
// burst sequencing, calibration, detection and serial response of the wheel sensor
`timescale 1ns/1ps
module twd_core #(
  parameter int CW = 12,
  parameter int TOUCH_THR = 16,
  parameter int BURST_GAP_CYC = twd_pkg::BURST_GAP_CYC,
  parameter int WAKE_FLOAT_CYC = twd_pkg::WAKE_FLOAT_CYC,
  parameter int WAKE_SETTLE_CYC = twd_pkg::WAKE_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial pins from the host
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // status pins
  output logic detect,
  output logic detect_oe_n,
  output logic host_may_talk_out,
  output logic host_may_talk_oe_n,
  // acquisition front end
  output logic burst_start,
  input wire logic burst_done,
  input wire logic [CW-1:0] sense_point_one,
  input wire logic [CW-1:0] sense_point_two,
  input wire logic [CW-1:0] sense_point_three,
  // position result
  output logic [6:0] position
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  localparam int TW = twd_pkg::TMR_W;
  if (CW < 2 || CW > 24 || TOUCH_THR < 1 || TOUCH_THR >= 2 ** CW) begin : g_bad_cw
    $error("twd_core: count width or threshold out of range");
  end
  if (BURST_GAP_CYC < 1 || BURST_GAP_CYC >= 2 ** TW || WAKE_FLOAT_CYC < 1 ||
      WAKE_FLOAT_CYC >= 2 ** TW || WAKE_SETTLE_CYC < 1 ||
      WAKE_SETTLE_CYC >= 2 ** TW) begin : g_bad_tmr
    $error("twd_core: timer count out of range");
  end
  localparam logic [TW-1:0] GAP_T = TW'(BURST_GAP_CYC - 1);
  localparam logic [TW-1:0] FLOAT_T = TW'(WAKE_FLOAT_CYC - 1);
  localparam logic [TW-1:0] SETTLE_T = TW'(WAKE_SETTLE_CYC - 1);
  localparam logic [CW:0] THR = (CW + 1)'(TOUCH_THR);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CAL_GAP,
    ST_BURST,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE,
    ST_SETTLE
  } twd_st_e;

  typedef struct packed {
    logic ss_m, ss_s, ss_d;
    logic sclk_m, sclk_s, sclk_d;
    logic mosi_m, mosi_s;
    twd_st_e st;
    logic [TW-1:0] tmr;
    logic [twd_pkg::CAL_W-1:0] cal_left;
    logic cal_active;
    logic in_frame;
    logic [3:0] bits;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [2:0][CW-1:0] cnt;
    logic [2:0][CW-1:0] refc;
    logic eval;
    logic detect;
    logic err;
    logic burst_start;
    logic talk;
    logic float_out;
    logic miso_oe_n;
  } twd_state_s;

  twd_state_s s_r, s_nxt;

  // ----------------------------------------------------------------
  // per-channel balance against the calibrated reference
  // ----------------------------------------------------------------
  logic [2:0][CW-1:0] mag, drift_ref;
  logic [2:0] over, neg;
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [CW:0] dlt;
    assign dlt = {1'b0, s_r.cnt[i]} - {1'b0, s_r.refc[i]};
    assign neg[i] = dlt[CW];
    assign mag[i] = neg[i] ? CW'(-dlt) : dlt[CW-1:0];
    assign over[i] = {1'b0, mag[i]} >= THR;
    // one count per command toward the latest reading
    assign drift_ref[i] = (s_r.cnt[i] > s_r.refc[i]) ? s_r.refc[i] + 1'b1 :
                          (s_r.cnt[i] < s_r.refc[i]) ? s_r.refc[i] - 1'b1 : s_r.refc[i];
  end

  logic touch_now, cal_start;
  logic [1:0] n_over;
  logic [7:0] rsp;
  logic sclk_rise, sclk_fall, ss_fall, ss_rise;

  always_comb begin
    n_over = 2'({1'b0, over[0]} + {1'b0, over[1]} + {1'b0, over[2]});
    touch_now = (n_over == 2'h1) || (n_over == 2'h2);
    rsp = 8'h00;
    rsp[twd_pkg::RSP_TOUCH_BIT] = s_r.detect;
    rsp[twd_pkg::RSP_ERROR_BIT] = s_r.err;
    sclk_rise = s_r.sclk_s & ~s_r.sclk_d;
    sclk_fall = ~s_r.sclk_s & s_r.sclk_d;
    ss_fall = ~s_r.ss_s & s_r.ss_d;
    ss_rise = s_r.ss_s & ~s_r.ss_d;
    cal_start = 1'b0;
    s_nxt = s_r;
    s_nxt.burst_start = 1'b0;
    s_nxt.eval = 1'b0;
    // pins cross into this clock through two flops before use
    s_nxt.ss_m = ss_n;
    s_nxt.ss_s = s_r.ss_m;
    s_nxt.ss_d = s_r.ss_s;
    s_nxt.sclk_m = sclk;
    s_nxt.sclk_s = s_r.sclk_m;
    s_nxt.sclk_d = s_r.sclk_s;
    s_nxt.mosi_m = mosi;
    s_nxt.mosi_s = s_r.mosi_m;
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - 1'b1;
    end

    // serial shifter; ignored entirely while calibrating
    if (!s_r.cal_active) begin
      if (ss_fall) begin
        s_nxt.tx = rsp;
        s_nxt.bits = 4'h0;
        s_nxt.in_frame = 1'b1;
      end else if (s_r.in_frame && !s_r.ss_s) begin
        if (sclk_rise && s_r.bits != twd_pkg::FRAME_BITS) begin
          s_nxt.rx = {s_r.rx[6:0], s_r.mosi_s};
          s_nxt.bits = s_r.bits + 1'b1;
        end
        // the first fall only opens the frame; bit 7 must stand until the first rise
        if (sclk_fall && s_r.bits != 4'h0) begin
          s_nxt.tx = {s_r.tx[6:0], 1'b0};
        end
      end
    end

    case (s_r.st)
      ST_CAL_GAP: begin
        if (s_r.tmr == '0) begin
          s_nxt.burst_start = 1'b1;
          s_nxt.st = ST_BURST;
        end
      end
      ST_BURST: begin
        if (burst_done) begin
          s_nxt.cnt = {sense_point_three, sense_point_two, sense_point_one};
          if (s_r.cal_active) begin
            s_nxt.refc = {sense_point_three, sense_point_two, sense_point_one};
            s_nxt.cal_left = s_r.cal_left - 1'b1;
            if (s_r.cal_left == 5'h01) begin
              s_nxt.cal_active = 1'b0;
              s_nxt.err = 1'b0;
              s_nxt.st = ST_IDLE;
            end else begin
              s_nxt.tmr = GAP_T;
              s_nxt.st = ST_CAL_GAP;
            end
          end else begin
            s_nxt.eval = 1'b1;
            s_nxt.st = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        if (ss_fall) begin
          s_nxt.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (ss_rise) begin
          s_nxt.in_frame = 1'b0;
          if (s_r.in_frame && s_r.bits == twd_pkg::FRAME_BITS &&
              s_r.rx == twd_pkg::CMD_CAL) begin
            cal_start = 1'b1;
          end else begin
            if (s_r.in_frame && s_r.bits == twd_pkg::FRAME_BITS &&
                s_r.rx == twd_pkg::CMD_DRIFT) begin
              s_nxt.refc = drift_ref;
            end
            s_nxt.tmr = FLOAT_T;
            s_nxt.st = ST_WAKE;
          end
        end
      end
      ST_WAKE: begin
        if (s_r.tmr == '0) begin
          s_nxt.tmr = SETTLE_T;
          s_nxt.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (s_r.tmr == '0) begin
          s_nxt.burst_start = 1'b1;
          s_nxt.st = ST_BURST;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (cal_start) begin
      s_nxt.cal_active = 1'b1;
      s_nxt.cal_left = twd_pkg::CAL_BURSTS;
      s_nxt.tmr = GAP_T;
      s_nxt.st = ST_CAL_GAP;
      s_nxt.detect = 1'b0;
    end

    // detection after each normal burst; an inverted channel means a
    // finger was calibrated away, so flag it but still report
    if (s_r.eval) begin
      s_nxt.detect = touch_now;
      if (touch_now && |(neg & over)) begin
        s_nxt.err = 1'b1;
      end
    end

    s_nxt.float_out = (s_nxt.st == ST_WAKE);
    s_nxt.talk = !s_nxt.cal_active &&
                 (s_nxt.st == ST_IDLE || s_nxt.st == ST_SLEEP);
    s_nxt.miso_oe_n = s_r.ss_s | s_nxt.cal_active;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.ss_m <= 1'b1;
      s_r.ss_s <= 1'b1;
      s_r.ss_d <= 1'b1;
      s_r.sclk_m <= 1'b1;
      s_r.sclk_s <= 1'b1;
      s_r.sclk_d <= 1'b1;
      s_r.st <= ST_CAL_GAP;
      s_r.tmr <= GAP_T;
      s_r.cal_active <= 1'b1;
      s_r.cal_left <= twd_pkg::CAL_BURSTS + twd_pkg::PWRUP_EXTRA_BURSTS;
      s_r.miso_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // position and outputs
  // ----------------------------------------------------------------
  twd_pos_calc #(
    .CW(CW)
  ) u_pos (
    .clk(clk),
    .srst(srst),
    .mag_one(mag[0]),
    .mag_two(mag[1]),
    .mag_three(mag[2]),
    .load(s_r.eval),
    .valid(touch_now),
    .clr(cal_start),
    .pos(position)
  );

  assign miso = s_r.tx[7];
  assign miso_oe_n = s_r.miso_oe_n;
  assign detect = s_r.detect;
  assign detect_oe_n = s_r.float_out;
  assign host_may_talk_out = s_r.talk;
  assign host_may_talk_oe_n = s_r.float_out;
  assign burst_start = s_r.burst_start;
endmodule // twd_core

// ===== tb/twd_monitor.sv
// port timing checker for the wheel sensor core
`timescale 1ns/1ps
module twd_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial and status pins
  input wire logic ss_n,
  input wire logic miso_oe_n,
  input wire logic detect,
  input wire logic detect_oe_n,
  input wire logic host_may_talk_out,
  input wire logic host_may_talk_oe_n,
  // front end and result
  input wire logic burst_start,
  input wire logic burst_done,
  input wire logic [6:0] position
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RDY_LOW_BURST: assert property (burst_start |-> !host_may_talk_out)
    else $error("ready high while a burst starts");
  AST_POS_ZERO: assert property (!detect_oe_n && !detect |-> position == 7'h00)
    else $error("position reported without touch");
  AST_DET_AFTER_BURST: assert property ($rose(detect) |->
    $past(burst_done, 2) || $past(burst_done, 3))
    else $error("touch flag rose without a burst result");
  AST_WAKE_FLOAT: assert property ($rose(detect_oe_n) |->
    detect_oe_n [*8] ##[0:2] !detect_oe_n)
    else $error("wake float length wrong");
  AST_OE_PAIR: assert property (host_may_talk_oe_n == detect_oe_n)
    else $error("ready and touch flag float apart");
  AST_SETTLE: assert property ($fell(detect_oe_n) |->
    !burst_start [*6] ##[1:4] burst_start)
    else $error("settle wait before burst wrong");
  AST_MISO_FRAME: assert property ($fell(miso_oe_n) |->
    !ss_n && $past(ss_n, 3) == 1'b0)
    else $error("data out driven outside a frame");
  AST_ONE_BURST: assert property (burst_start |=> !burst_start)
    else $error("burst request longer than one cycle");
endmodule // twd_monitor

bind twd_core twd_monitor u_twd_monitor (.clk(clk), .srst(srst), .ss_n(ss_n),
  .miso_oe_n(miso_oe_n), .detect(detect), .detect_oe_n(detect_oe_n),
  .host_may_talk_out(host_may_talk_out), .host_may_talk_oe_n(host_may_talk_oe_n),
  .burst_start(burst_start), .burst_done(burst_done), .position(position));

// ===== tb/twd_host_model.sv
// host side of the serial link, one frame per call
`timescale 1ns/1ps
module twd_host_model (
  // serial pins toward the core
  output logic ss_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  logic last_q;
  initial begin
    ss_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
    last_q = 1'b0;
  end
  // a released data line shows the inverse of its last level, never a kind value
  always @(miso or miso_oe_n) if (!miso_oe_n) last_q = miso;
  task automatic frame(input logic [7:0] cmd, output logic [7:0] rsp);
    ss_n <= 1'b0;
    #100;
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= cmd[i];
      #24;
      sclk <= 1'b1;
      rsp[i] = miso_oe_n ? ~last_q : miso;
      #24;
    end
    #100;
    ss_n <= 1'b1;
    mosi <= ~mosi;
  endtask
  // select pulse with no clocks still asks for one burst
  task automatic pulse();
    ss_n <= 1'b0;
    #100;
    ss_n <= 1'b1;
  endtask
endmodule // twd_host_model

// ===== tb/testbench.sv
// self-checking bench for the wheel sensor core
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] BASE = 12'h400;
  logic clk, srst, ss_n, sclk, mosi, miso, miso_oe_n, detect, detect_oe_n;
  logic rdy, rdy_oe_n, burst_start, burst_done;
  logic [11:0] pt [3];
  logic [6:0] position;
  logic [7:0] rsp, exp_q;
  int error_cnt, samples_checked, bursts, k;
  twd_core #(.BURST_GAP_CYC(20), .WAKE_FLOAT_CYC(8), .WAKE_SETTLE_CYC(8)) u_twd_core (
    .clk(clk), .srst(srst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .detect(detect), .detect_oe_n(detect_oe_n),
    .host_may_talk_out(rdy), .host_may_talk_oe_n(rdy_oe_n), .burst_start(burst_start),
    .burst_done(burst_done), .sense_point_one(pt[0]), .sense_point_two(pt[1]),
    .sense_point_three(pt[2]), .position(position));
  twd_host_model u_twd_host_model (.ss_n(ss_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // front end answers each burst one cycle later with the counts held in pt
  always @(posedge clk) begin
    burst_done <= burst_start;
    if (burst_start) bursts <= bursts + 1;
  end
  function automatic logic [7:0] rsp_of(input logic t, input logic e);
    return {t, 5'h00, e, 1'b0};
  endfunction
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy(input int b);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (rdy === 1'b1 && rdy_oe_n === 1'b0 && bursts > b) return;
    end
    error_cnt++;
    complete_run();
  endtask
  task automatic set_pt(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
    @(posedge clk);
    pt[0] <= a;
    pt[1] <= b;
    pt[2] <= c;
  endtask
  // the answer of a frame is the state left by the burst of the frame before
  task automatic xfer(input logic [7:0] cmd, input int n);
    int b;
    b = bursts;
    u_twd_host_model.frame(cmd, rsp);
    cmp("response", {4'h0, exp_q}, {4'h0, rsp});
    wait_rdy(b);
    cmp("bursts", 12'(n), 12'(bursts - b));
    repeat (3) @(posedge clk);
  endtask
  task automatic chk(input logic t, input logic e, input logic [6:0] p);
    cmp("detect", {11'h000, t}, {11'h000, detect});
    cmp("position", {5'h00, p}, {5'h00, position});
    exp_q = rsp_of(t, e);
  endtask
  task automatic touch(input int c, input int d);
    logic [11:0] v [3];
    v = '{BASE, BASE, BASE};
    v[c] = BASE + 12'(d);
    set_pt(v[0], v[1], v[2]);
    xfer(8'h00, 1);
    if (c == 2) cmp("pos_three", 12'h001, {11'h000, position === 7'h00 || position === 7'h7f});
    else chk(1'b1, 1'b0, c == 1 ? twd_pkg::POS_PT2 : twd_pkg::POS_PT1);
    exp_q = rsp_of(1'b1, 1'b0);
  endtask
  initial begin
    void'($urandom(76));
    srst = 1'b1;
    burst_done = 1'b0;
    bursts = 0;
    error_cnt = 0;
    samples_checked = 0;
    pt = '{BASE, BASE, BASE};
    exp_q = 8'h00;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    wait_rdy(0);
    cmp("pwrup_bursts", 12'h010, 12'(bursts));
    for (k = 0; k < 3; k++) touch(k, 64);
    repeat (6) touch($urandom_range(2), $urandom_range(511, 16));
    set_pt(BASE + 12'h060, BASE + 12'h060, BASE);
    xfer(8'h00, 1);
    chk(1'b1, 1'b0, 7'h40);
    set_pt(BASE + 12'h12c, BASE + 12'h12c, BASE + 12'h12c);
    xfer(8'h00, 1);
    chk(1'b0, 1'b0, 7'h00);
    set_pt(BASE + 12'h010, BASE, BASE);
    xfer(8'h00, 1);
    chk(1'b1, 1'b0, twd_pkg::POS_PT1);
    xfer(twd_pkg::CMD_DRIFT, 1);
    chk(1'b0, 1'b0, 7'h00);
    k = bursts;
    u_twd_host_model.pulse();
    wait_rdy(k);
    cmp("pulse_bursts", 12'h001, 12'(bursts - k));
    repeat (3) @(posedge clk);
    chk(1'b0, 1'b0, 7'h00);
    set_pt(BASE + 12'h0c8, BASE, BASE);
    xfer(twd_pkg::CMD_CAL, 10);
    chk(1'b0, 1'b0, 7'h00);
    set_pt(BASE, BASE, BASE);
    xfer(twd_pkg::CMD_ERROR, 1);
    cmp("false_touch", 12'h001, {11'h000, detect});
    exp_q = rsp_of(1'b1, 1'b1);
    xfer(twd_pkg::CMD_CAL, 10);
    chk(1'b0, 1'b0, 7'h00);
    xfer(8'h00, 1);
    complete_run();
  end
endmodule // testbench
